// >>> rtl/hmaf_filter.v
// HDLC mode handling, receive address filter and transmit frame builder.
`timescale 1ns/100ps
`default_nettype none
`include "hmaf_map.vh"
module hmaf_filter
#(
  parameter W = 8
)
(
  // Clock and reset.
  input wire I_MCLK,
  input wire I_RSTN,
  // Mode and configuration bits.
  input wire I_MODE_SELECT_HI,
  input wire I_MODE_SELECT_LO,
  input wire I_ADDRESS_MODE_BIT,
  input wire I_CR_BIT_INTERPRET,
  input wire I_STORE_RX_CRC,
  input wire I_STORE_RX_ADDRESS,
  input wire I_EXTERNAL_TX_CHECKSUM,
  // Address compare values and don't-care masks.
  input wire [W-1:0] I_HIGH_ADDR_COMPARE_A,
  input wire [W-1:0] I_HIGH_ADDR_COMPARE_B,
  input wire [W-1:0] I_LOW_ADDR_COMPARE_A,
  input wire [W-1:0] I_LOW_ADDR_COMPARE_B,
  input wire [W-1:0] I_HIGH_ADDR_MASK,
  input wire [W-1:0] I_LOW_ADDR_MASK,
  // Received bytes from the deframer.
  input wire I_RX_VALID,
  input wire [W-1:0] I_RX_DATA,
  input wire I_RX_SOF,
  input wire I_RX_EOF,
  input wire I_RX_IS_CRC,
  input wire [W-1:0] I_RX_FRAME_STATUS,
  output wire O_RX_READY,
  // Receive FIFO write side.
  output wire O_RECEIVE_FIFO_VALID,
  output wire [W-1:0] O_RECEIVE_FIFO_DATA,
  input wire I_RECEIVE_FIFO_READY,
  // Receive side registers and frame flags.
  output wire [W-1:0] O_RECEIVED_CONTROL_BYTE,
  output wire [W-1:0] O_RECEIVE_STATUS_BYTE,
  output wire [W-1:0] O_LOW_ADDR_CAPTURE,
  output wire O_RX_AUTO_PROCESS,
  output wire O_RX_RESPONSE,
  // Line framing controls.
  output wire O_FRAMING_ON,
  output wire O_TX_CRC_GEN,
  // Transmit commands and generated header fields.
  input wire I_SEND_INFO_FRAME_CMD,
  input wire I_SEND_TRANSPARENT_FRAME_CMD,
  input wire [W-1:0] I_TX_ADDR_HI,
  input wire [W-1:0] I_TX_ADDR_LO,
  input wire [W-1:0] I_TX_CONTROL,
  output wire O_CMD_REJECT,
  output wire O_TX_BUSY,
  // Transmit FIFO read side.
  input wire I_TRANSMIT_FIFO_VALID,
  input wire [W-1:0] I_TRANSMIT_FIFO_DATA,
  input wire I_TRANSMIT_FIFO_LAST,
  output wire O_TRANSMIT_FIFO_READY,
  // Transmit byte stream to the serialiser.
  output wire O_TX_VALID,
  output wire [W-1:0] O_TX_DATA,
  output wire O_TX_LAST,
  input wire I_TX_READY
);
  wire [1:0] mode; // Mode select pair.
  wire address_mode_bit; // Address mode bit.
  wire [W-1:0] b; // Byte under inspection.
  wire [W-1:0] hmask; // Active compare bits of the high byte.
  wire [W-1:0] lmask; // Active compare bits of the low byte.
  wire hi_a, hi_b, hi_grp; // High byte matches.
  wire lo_a, lo_b; // Low byte matches.
  wire accept; // A received byte is taken this cycle.
  wire [1:0] pos; // Byte position inside the frame.
  wire buf_ready;
  wire [1:0] buf_cnt;
  wire pend_push; // Pending byte goes into the buffer.
  reg [1:0] idx_r; // Saturating byte counter of the frame.
  reg drop_r; // Rest of the frame is discarded.
  reg hi_a_r, hi_b_r, hi_grp_r; // Stored high byte matches.
  reg [W-1:0] hi_byte_r; // Stored high address byte.
  reg [W-1:0] ctrl_r, stat_r, lowcap_r;
  reg auto_r, resp_r, rdy_r;
  reg pend_r; // A second byte waits for the buffer.
  reg [W-1:0] pend_d_r;
  // Combinational decisions on the accepted byte.
  reg push_byte;
  reg [W-1:0] push_d;
  reg set_pend;
  reg [W-1:0] set_pend_d;
  reg drop_nxt, cap_ctrl, cap_low, keep_hi, set_match;
  reg auto_nxt, resp_nxt;
  reg [1:0] lvl_nxt;
  reg pend_nxt;
  wire buf_push;
  wire [W-1:0] buf_d;

  assign mode = {I_MODE_SELECT_HI, I_MODE_SELECT_LO};
  assign address_mode_bit = I_ADDRESS_MODE_BIT;
  assign b = I_RX_DATA;
  // Any masked bits leave the comparison; the command/response bit leaves the high byte comparison when it is interpreted.
  assign hmask = ~I_HIGH_ADDR_MASK & (I_CR_BIT_INTERPRET ? `HMAF_CMP_NO_CR : `HMAF_CMP_ALL);
  assign lmask = ~I_LOW_ADDR_MASK;
  assign hi_a = ((b ^ I_HIGH_ADDR_COMPARE_A) & hmask) == {W{1'b0}};
  assign hi_b = ((b ^ I_HIGH_ADDR_COMPARE_B) & hmask) == {W{1'b0}};
  assign hi_grp = (((b ^ `HMAF_GROUP_HI_A) & hmask) == {W{1'b0}})
    || (((b ^ `HMAF_GROUP_HI_B) & hmask) == {W{1'b0}});
  assign lo_a = ((b ^ I_LOW_ADDR_COMPARE_A) & lmask) == {W{1'b0}};
  assign lo_b = ((b ^ I_LOW_ADDR_COMPARE_B) & lmask) == {W{1'b0}};
  assign accept = I_RX_VALID && rdy_r;
  assign pos = I_RX_SOF ? 2'h0 : idx_r;

  // Per-byte receive decision, by operating mode.
  always @*
  begin
    push_byte = 1'b0;
    push_d = b;
    set_pend = 1'b0;
    set_pend_d = b;
    drop_nxt = drop_r;
    cap_ctrl = 1'b0;
    cap_low = 1'b0;
    keep_hi = 1'b0;
    set_match = 1'b0;
    auto_nxt = auto_r;
    resp_nxt = resp_r;
    if (I_RX_SOF)
      drop_nxt = 1'b0;
    case (mode)
      `HMAF_MODE_AUTO, `HMAF_MODE_NONAUTO:
      begin
        if (address_mode_bit && pos == 2'h0)
        begin
          // High byte is held until the low byte decides the frame.
          keep_hi = 1'b1;
        end
        else if (address_mode_bit && pos == 2'h1)
        begin
          set_match = 1'b1;
          drop_nxt = !((hi_a_r || hi_b_r || hi_grp_r) && (lo_a || lo_b));
          auto_nxt = (mode == `HMAF_MODE_AUTO) && hi_a_r && lo_a;
          resp_nxt = I_CR_BIT_INTERPRET && hi_byte_r[`HMAF_CR_BIT];
          if (!drop_nxt && I_STORE_RX_ADDRESS)
          begin
            push_byte = 1'b1;
            push_d = hi_byte_r;
            set_pend = 1'b1;
          end
        end
        else if (!address_mode_bit && pos == 2'h0)
        begin
          drop_nxt = !(lo_a || lo_b);
          auto_nxt = (mode == `HMAF_MODE_AUTO) && !drop_nxt;
          resp_nxt = !lo_a && lo_b;
          push_byte = !drop_nxt && I_STORE_RX_ADDRESS;
        end
        else if (!drop_r)
        begin
          // Control byte, then information field; all valid frames alike.
          cap_ctrl = (pos == (address_mode_bit ? 2'h2 : 2'h1));
          push_byte = !I_RX_IS_CRC || I_STORE_RX_CRC;
        end
      end
      `HMAF_MODE_TRANSP:
      begin
        if (address_mode_bit && pos == 2'h0)
        begin
          drop_nxt = !(hi_a || hi_b || hi_grp);
          resp_nxt = I_CR_BIT_INTERPRET && b[`HMAF_CR_BIT];
          push_byte = !drop_nxt && I_STORE_RX_ADDRESS;
        end
        else if (!drop_nxt)
        begin
          // A start byte clears the discard state, so a dropped frame cannot eat it.
          // Transparent 1 captures bytes two and three, transparent 0 one and two.
          cap_low = address_mode_bit ? (pos == 2'h1) : (pos == 2'h0);
          cap_ctrl = address_mode_bit ? (pos == 2'h2) : (pos == 2'h1);
          push_byte = !I_RX_IS_CRC || I_STORE_RX_CRC;
        end
        auto_nxt = 1'b0;
      end
      `HMAF_MODE_EXTTR:
      begin
        // No framing: every byte is the current byte, stored in mode 1.
        cap_low = 1'b1;
        push_byte = address_mode_bit;
        drop_nxt = 1'b0;
        auto_nxt = 1'b0;
      end
      default:
      begin
        // Reserved codes discard everything.
        drop_nxt = 1'b1;
      end
    endcase
    // A frame end appends the status byte unless the frame was discarded.
    if (I_RX_EOF && mode != `HMAF_MODE_EXTTR && !drop_nxt)
    begin
      set_pend = 1'b1;
      set_pend_d = I_RX_FRAME_STATUS;
    end
  end

  assign pend_push = pend_r && buf_ready;
  assign buf_push = (accept && push_byte) || pend_push;
  assign buf_d = pend_r ? pend_d_r : push_d;

  // Fill level and pending slot after this cycle, for the ready flop.
  always @*
  begin
    lvl_nxt = buf_cnt;
    if (buf_push && !(O_RECEIVE_FIFO_VALID && I_RECEIVE_FIFO_READY))
      lvl_nxt = buf_cnt + 2'h1;
    else if (!buf_push && O_RECEIVE_FIFO_VALID && I_RECEIVE_FIFO_READY)
      lvl_nxt = buf_cnt - 2'h1;
    pend_nxt = (pend_r && !pend_push) || (accept && set_pend);
  end

  // Receive state, side registers and the pending byte.
  always @(posedge I_MCLK)
  begin
    if (!I_RSTN)
    begin
      idx_r <= 2'h0;
      drop_r <= 1'b1;
      hi_a_r <= 1'b0;
      hi_b_r <= 1'b0;
      hi_grp_r <= 1'b0;
      hi_byte_r <= `HMAF_BYTE_RST;
      ctrl_r <= `HMAF_BYTE_RST;
      stat_r <= `HMAF_BYTE_RST;
      lowcap_r <= `HMAF_BYTE_RST;
      auto_r <= 1'b0;
      resp_r <= 1'b0;
      rdy_r <= 1'b0;
      pend_r <= 1'b0;
      pend_d_r <= `HMAF_BYTE_RST;
    end
    else
    begin
      // Ready also drops after every framed end byte, kept or discarded alike.
      rdy_r <= !pend_nxt && (lvl_nxt != 2'h2)
        && !(accept && I_RX_EOF && (mode != `HMAF_MODE_EXTTR));
      pend_r <= pend_nxt;
      if (accept)
      begin
        idx_r <= (pos == 2'h3) ? 2'h3 : pos + 2'h1;
        drop_r <= drop_nxt;
        auto_r <= auto_nxt;
        resp_r <= resp_nxt;
        if (set_pend)
          pend_d_r <= set_pend_d;
        if (I_RX_EOF && set_pend)
          stat_r <= I_RX_FRAME_STATUS;
        if (cap_ctrl)
          ctrl_r <= b;
        if (cap_low)
          lowcap_r <= b;
        if (keep_hi)
        begin
          hi_byte_r <= b;
          hi_a_r <= hi_a;
          hi_b_r <= hi_b;
          hi_grp_r <= hi_grp;
        end
      end
    end
  end

  // Two-entry buffer in front of the receive FIFO.
  hmaf_buf2 #(.W(W)) u_rxbuf
  (
    .i_clk(I_MCLK),
    .i_rst_n(I_RSTN),
    .i_in_valid(buf_push),
    .i_in_data(buf_d),
    .o_in_ready(buf_ready),
    .o_out_valid(O_RECEIVE_FIFO_VALID),
    .o_out_data(O_RECEIVE_FIFO_DATA),
    .i_out_ready(I_RECEIVE_FIFO_READY),
    .o_count(buf_cnt)
  );

  assign O_RX_READY = rdy_r;
  assign O_RECEIVED_CONTROL_BYTE = ctrl_r;
  assign O_RECEIVE_STATUS_BYTE = stat_r;
  assign O_LOW_ADDR_CAPTURE = lowcap_r;
  assign O_RX_AUTO_PROCESS = auto_r;
  assign O_RX_RESPONSE = resp_r;

  // Transmit side.
  reg [2:0] tx_st_r; // Sequencer state.
  reg txv_r, txl_r, txf_rdy_r, rej_r, fr_on_r, crc_r, two_r;
  reg [W-1:0] txd_r;
  wire tx_free; // Output slot empty or leaving this cycle.
  wire txf_take;

  assign tx_free = !txv_r || I_TX_READY;
  assign txf_take = txf_rdy_r && I_TRANSMIT_FIFO_VALID;

  // Frame builder: generated header for info frames, FIFO bytes for both.
  always @(posedge I_MCLK)
  begin
    if (!I_RSTN)
    begin
      tx_st_r <= `HMAF_TX_IDLE;
      txv_r <= 1'b0;
      txl_r <= 1'b0;
      txd_r <= `HMAF_BYTE_RST;
      txf_rdy_r <= 1'b0;
      rej_r <= 1'b0;
      fr_on_r <= 1'b1;
      crc_r <= 1'b1;
      two_r <= 1'b0;
    end
    else
    begin
      fr_on_r <= (mode != `HMAF_MODE_EXTTR);
      rej_r <= 1'b0;
      if (txv_r && I_TX_READY)
        txv_r <= 1'b0;
      txf_rdy_r <= 1'b0;
      case (tx_st_r)
        `HMAF_TX_IDLE:
        begin
          // Checksum is generated only in framed modes without external CRC.
          crc_r <= !I_EXTERNAL_TX_CHECKSUM && (mode != `HMAF_MODE_EXTTR);
          two_r <= address_mode_bit;
          if (I_SEND_INFO_FRAME_CMD && mode == `HMAF_MODE_AUTO)
            tx_st_r <= `HMAF_TX_ADDR_HI;
          else if (I_SEND_INFO_FRAME_CMD)
            rej_r <= 1'b1;
          else if (I_SEND_TRANSPARENT_FRAME_CMD)
            tx_st_r <= `HMAF_TX_DATA;
        end
        `HMAF_TX_ADDR_HI, `HMAF_TX_ADDR_LO, `HMAF_TX_CTRL:
        begin
          if (tx_free)
          begin
            txv_r <= 1'b1;
            txl_r <= 1'b0;
            if (tx_st_r == `HMAF_TX_CTRL)
            begin
              txd_r <= I_TX_CONTROL;
              tx_st_r <= `HMAF_TX_DATA;
            end
            else if (tx_st_r == `HMAF_TX_ADDR_HI && two_r)
            begin
              txd_r <= I_TX_ADDR_HI;
              tx_st_r <= `HMAF_TX_ADDR_LO;
            end
            else
            begin
              txd_r <= I_TX_ADDR_LO;
              tx_st_r <= `HMAF_TX_CTRL;
            end
          end
        end
        `HMAF_TX_DATA:
        begin
          // FIFO length is taken as given; the last byte closes the frame.
          if (txf_take)
          begin
            txv_r <= 1'b1;
            txd_r <= I_TRANSMIT_FIFO_DATA;
            txl_r <= I_TRANSMIT_FIFO_LAST;
            if (I_TRANSMIT_FIFO_LAST)
              tx_st_r <= `HMAF_TX_IDLE;
          end
          else
            txf_rdy_r <= tx_free && !txf_rdy_r;
        end
        default:
        begin
          tx_st_r <= `HMAF_TX_IDLE;
        end
      endcase
    end
  end

  assign O_TX_VALID = txv_r;
  assign O_TX_DATA = txd_r;
  assign O_TX_LAST = txl_r;
  assign O_TRANSMIT_FIFO_READY = txf_rdy_r;
  assign O_CMD_REJECT = rej_r;
  assign O_TX_BUSY = (tx_st_r != `HMAF_TX_IDLE);
  assign O_FRAMING_ON = fr_on_r;
  assign O_TX_CRC_GEN = crc_r;
endmodule
`default_nettype wire

// >>> shared/hmaf_map.vh
// Constants for the HDLC mode and address filter block.
`ifndef HMAF_MAP_VH
`define HMAF_MAP_VH
// Mode select codes, high bit then low bit.
`define HMAF_MODE_AUTO 2'h0
`define HMAF_MODE_NONAUTO 2'h1
`define HMAF_MODE_TRANSP 2'h2
`define HMAF_MODE_EXTTR 2'h3
// Fixed group values for the high address byte.
`define HMAF_GROUP_HI_A 8'hFE
`define HMAF_GROUP_HI_B 8'hFC
// Compare mask with and without the command/response bit.
`define HMAF_CMP_ALL 8'hFF
`define HMAF_CMP_NO_CR 8'hFD
// Position of the command/response bit in the high address byte.
`define HMAF_CR_BIT 1
// Reset value of the captured bytes.
`define HMAF_BYTE_RST 8'h00
// Transmit sequencer states.
`define HMAF_TX_IDLE 3'h0
`define HMAF_TX_ADDR_HI 3'h1
`define HMAF_TX_ADDR_LO 3'h2
`define HMAF_TX_CTRL 3'h3
`define HMAF_TX_DATA 3'h4
`endif

// >>> rtl/hmaf_buf2.v
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module hmaf_buf2
#(
  parameter W = 8
)
(
  // Clock and reset.
  input wire i_clk,
  input wire i_rst_n,
  // Filling side.
  input wire i_in_valid,
  input wire [W-1:0] i_in_data,
  output wire o_in_ready,
  // Draining side.
  output wire o_out_valid,
  output wire [W-1:0] o_out_data,
  input wire i_out_ready,
  // Current number of held entries.
  output wire [1:0] o_count
);
  reg [W-1:0] head_r; // Oldest entry, presented at the output.
  reg [W-1:0] tail_r; // Second entry.
  reg [1:0] cnt_r; // Number of entries held.
  reg rdy_r; // Room for one more entry.
  reg val_r; // Head entry is valid.
  wire push;
  wire pop;
  reg [1:0] cnt_nxt;

  assign push = i_in_valid && rdy_r;
  assign pop = val_r && i_out_ready;
  assign o_in_ready = rdy_r;
  assign o_out_valid = val_r;
  assign o_out_data = head_r;
  assign o_count = cnt_r;

  // Next fill level from the push and pop of this cycle.
  always @*
  begin
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + 2'h1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 2'h1;
  end

  // Entry storage; the head shifts up on a pop.
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      head_r <= {W{1'b0}};
      tail_r <= {W{1'b0}};
      cnt_r <= 2'h0;
      rdy_r <= 1'b0;
      val_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != 2'h2);
      val_r <= (cnt_nxt != 2'h0);
      if (pop)
      begin
        // The head takes the tail or the new word when it was the last one.
        if (cnt_r == 2'h2)
          head_r <= tail_r;
        else
          head_r <= i_in_data;
        if (push)
          tail_r <= i_in_data;
      end
      else if (push)
      begin
        if (cnt_r == 2'h0)
          head_r <= i_in_data;
        else
          tail_r <= i_in_data;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/hmaf_remote.sv
// Far-side model that drains the receive FIFO and the transmit byte stream.
`timescale 1ns/100ps
`default_nettype none
module hmaf_remote
#(
  parameter int SLOW = 1
)
(
  // Clock.
  input wire logic clk,
  // Receive FIFO stream.
  input wire logic rf_valid,
  input wire logic [7:0] rf_data,
  output var logic rf_ready,
  // Transmit byte stream.
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output var logic tx_ready
);
  logic [8:0] rq[$]; // Bytes taken from the receive FIFO.
  logic [8:0] tq[$]; // Transmit bytes, bit 8 is the last flag.
  logic [3:0] ph = 4'h0; // Stall phase; slow mode drops ready often.
  initial rf_ready = 1'b0;
  initial tx_ready = 1'b0;
  // A byte is taken at an edge where valid and ready are both high.
  always @(posedge clk)
  begin
    ph <= ph + 4'h1;
    rf_ready <= (SLOW == 0) || ph[0];
    tx_ready <= (SLOW == 0) || (ph[1:0] != 2'h3);
    if (rf_valid && rf_ready)
      rq.push_back({1'b0, rf_data});
    if (tx_valid && tx_ready)
      tq.push_back({tx_last, tx_data});
  end
endmodule
`default_nettype wire

// >>> testbench/hmaf_filter_asserts.sv
// Concurrent checks on the ports of the mode handling and address filter.
`timescale 1ns/100ps
`default_nettype none
module hmaf_filter_chk
#(
  parameter W = 8
)
(
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic I_MODE_SELECT_HI,
  input wire logic I_MODE_SELECT_LO,
  input wire logic I_ADDRESS_MODE_BIT,
  input wire logic I_EXTERNAL_TX_CHECKSUM,
  input wire logic I_RX_VALID,
  input wire logic [W-1:0] I_RX_DATA,
  input wire logic I_RX_SOF,
  input wire logic I_RX_EOF,
  input wire logic O_RX_READY,
  input wire logic O_RECEIVE_FIFO_VALID,
  input wire logic [W-1:0] O_RECEIVE_FIFO_DATA,
  input wire logic I_RECEIVE_FIFO_READY,
  input wire logic [W-1:0] O_LOW_ADDR_CAPTURE,
  input wire logic O_FRAMING_ON,
  input wire logic O_TX_CRC_GEN,
  input wire logic I_SEND_INFO_FRAME_CMD,
  input wire logic I_SEND_TRANSPARENT_FRAME_CMD,
  input wire logic O_CMD_REJECT,
  input wire logic O_TX_BUSY,
  input wire logic O_TX_VALID
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  wire ext_m = I_MODE_SELECT_HI & I_MODE_SELECT_LO; // Extended transparent.
  wire auto_m = !I_MODE_SELECT_HI & !I_MODE_SELECT_LO; // Auto mode.
  wire tr0_m = I_MODE_SELECT_HI & !I_MODE_SELECT_LO & !I_ADDRESS_MODE_BIT; // Transparent 0.
  // A receive byte is taken; a command is seen while the sender is idle.
  sequence s_take;
    I_RX_VALID && O_RX_READY;
  endsequence
  sequence s_info;
    I_SEND_INFO_FRAME_CMD && !O_TX_BUSY;
  endsequence
  property p_ext_noframe;
    ext_m [*2] |-> !O_FRAMING_ON;
  endproperty
  a_ext_noframe: assert property (p_ext_noframe) else $error("framing on");
  property p_external_tx_checksum;
    !O_TX_BUSY && I_EXTERNAL_TX_CHECKSUM |=> !O_TX_CRC_GEN;
  endproperty
  a_external_tx_checksum: assert property (p_external_tx_checksum) else $error("crc generated");
  property p_info_rej;
    s_info ##0 !auto_m |=> O_CMD_REJECT && !O_TX_BUSY;
  endproperty
  a_info_rej: assert property (p_info_rej) else $error("no reject");
  property p_info_go;
    s_info ##0 auto_m |=> !O_CMD_REJECT ##1 O_TX_VALID;
  endproperty
  a_info_go: assert property (p_info_go) else $error("info not sent");
  property p_xtf;
    I_SEND_TRANSPARENT_FRAME_CMD && !O_TX_BUSY |=> O_TX_BUSY && !O_CMD_REJECT;
  endproperty
  a_xtf: assert property (p_xtf) else $error("transparent refused");
  property p_eof_gap;
    s_take ##0 I_RX_EOF && !ext_m |=> !O_RX_READY;
  endproperty
  a_eof_gap: assert property (p_eof_gap) else $error("no status slot");
  property p_tr0_cap;
    s_take ##0 I_RX_SOF && tr0_m |=> O_LOW_ADDR_CAPTURE == $past(I_RX_DATA);
  endproperty
  a_tr0_cap: assert property (p_tr0_cap) else $error("first byte lost");
  property p_ext_cap;
    s_take ##0 ext_m |=> O_LOW_ADDR_CAPTURE == $past(I_RX_DATA);
  endproperty
  a_ext_cap: assert property (p_ext_cap) else $error("byte not held");
  property p_fifo_hold;
    O_RECEIVE_FIFO_VALID && !I_RECEIVE_FIFO_READY |=>
      O_RECEIVE_FIFO_VALID && $stable(O_RECEIVE_FIFO_DATA);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("stalled word lost");
endmodule
bind hmaf_filter hmaf_filter_chk #(.W(W)) chk_u (.I_MCLK, .I_RSTN, .I_MODE_SELECT_HI,
  .I_MODE_SELECT_LO, .I_ADDRESS_MODE_BIT, .I_EXTERNAL_TX_CHECKSUM, .I_RX_VALID, .I_RX_DATA,
  .I_RX_SOF, .I_RX_EOF, .O_RX_READY, .O_RECEIVE_FIFO_VALID, .O_RECEIVE_FIFO_DATA,
  .I_RECEIVE_FIFO_READY, .O_LOW_ADDR_CAPTURE, .O_FRAMING_ON, .O_TX_CRC_GEN,
  .I_SEND_INFO_FRAME_CMD, .I_SEND_TRANSPARENT_FRAME_CMD, .O_CMD_REJECT, .O_TX_BUSY,
  .O_TX_VALID);
`default_nettype wire

// >>> testbench/hmaf_filter_test.sv
// Self-checking bench for the mode handling and address filter.
`timescale 1ns/100ps
`default_nettype none
module hmaf_filter_test;
  logic clk = 1'b0, rst_n = 1'b0; // Clock and reset.
  logic hi = 1'b0, lo = 1'b0, address_mode_bit = 1'b0, cr_bit_interpret = 1'b0; // Mode bits.
  logic scrc = 1'b0, sadd = 1'b0, xck = 1'b0; // Store and checksum options.
  logic [7:0] ha = 8'h30, hb = 8'h44, la = 8'h00, lb = 8'h01, am = 8'h00; // Compare values, mask.
  logic rv = 1'b0, rs = 1'b0, re = 1'b0, rc = 1'b0; // Receive byte qualifiers.
  logic [7:0] rd = 8'h00, fst = 8'h00; // Receive byte and frame status.
  logic ic = 1'b0, tc = 1'b0; // Transmit commands.
  logic [7:0] tah = 8'h00, tal = 8'h00, tct = 8'h00; // Info frame header.
  logic [7:0] tsrc [0:7]; // Transmit FIFO contents.
  int tlen = 0, tidx = 0; // Transmit FIFO fill and read position.
  logic rrdy, rf_v, rf_r, ap, resp, fon, crcg, rej, busy, frd, tx_v, tx_l, tx_r, fv, fl;
  logic [7:0] rf_d, cb, sb, cap, tx_d, fd;
  logic [8:0] eq[$]; // Expected stream entries.
  logic [7:0] st, x, lf = 8'h0B; // Frame status, scratch, random state.
  logic [7:0] fb [0:7]; // Frame being sent.
  int fn, fail_count = 0, n_tests = 0;
  assign fv = tidx < tlen;
  assign fd = fv ? tsrc[tidx[2:0]] : 8'h00;
  assign fl = tidx == tlen - 1;
  always #4 clk = ~clk;
  // The transmit FIFO advances on each read the design takes.
  always @(posedge clk)
    if (fv && frd)
      tidx <= tidx + 1;
  hmaf_filter dut_u (
    .I_MCLK(clk), .I_RSTN(rst_n), .I_MODE_SELECT_HI(hi), .I_MODE_SELECT_LO(lo),
    .I_ADDRESS_MODE_BIT(address_mode_bit), .I_CR_BIT_INTERPRET(cr_bit_interpret), .I_STORE_RX_CRC(scrc),
    .I_STORE_RX_ADDRESS(sadd), .I_EXTERNAL_TX_CHECKSUM(xck), .I_HIGH_ADDR_COMPARE_A(ha),
    .I_HIGH_ADDR_COMPARE_B(hb), .I_LOW_ADDR_COMPARE_A(la), .I_LOW_ADDR_COMPARE_B(lb),
    .I_HIGH_ADDR_MASK(am), .I_LOW_ADDR_MASK(am), .I_RX_VALID(rv), .I_RX_DATA(rd),
    .I_RX_SOF(rs), .I_RX_EOF(re), .I_RX_IS_CRC(rc), .I_RX_FRAME_STATUS(fst),
    .O_RX_READY(rrdy), .O_RECEIVE_FIFO_VALID(rf_v), .O_RECEIVE_FIFO_DATA(rf_d),
    .I_RECEIVE_FIFO_READY(rf_r), .O_RECEIVED_CONTROL_BYTE(cb), .O_RECEIVE_STATUS_BYTE(sb),
    .O_LOW_ADDR_CAPTURE(cap), .O_RX_AUTO_PROCESS(ap), .O_RX_RESPONSE(resp),
    .O_FRAMING_ON(fon), .O_TX_CRC_GEN(crcg), .I_SEND_INFO_FRAME_CMD(ic),
    .I_SEND_TRANSPARENT_FRAME_CMD(tc), .I_TX_ADDR_HI(tah), .I_TX_ADDR_LO(tal),
    .I_TX_CONTROL(tct), .O_CMD_REJECT(rej), .O_TX_BUSY(busy), .I_TRANSMIT_FIFO_VALID(fv),
    .I_TRANSMIT_FIFO_DATA(fd), .I_TRANSMIT_FIFO_LAST(fl), .O_TRANSMIT_FIFO_READY(frd),
    .O_TX_VALID(tx_v), .O_TX_DATA(tx_d), .O_TX_LAST(tx_l), .I_TX_READY(tx_r));
  hmaf_remote #(.SLOW(1)) p_u (.clk(clk), .rf_valid(rf_v), .rf_data(rf_d), .rf_ready(rf_r),
    .tx_valid(tx_v), .tx_data(tx_d), .tx_last(tx_l), .tx_ready(tx_r));
  // Pseudo-random bytes from a fixed seed.
  function automatic logic [7:0] next_rand();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  // Compare tasks for stream entries and flags.
  task automatic chk9(input logic [8:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, exp);
    chk9({8'h00, got}, {8'h00, exp});
  endtask
  task automatic finish_test();
    $display("%0d comparisons, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    $display("wrong value at %0t: wait ran out", $time);
    finish_test();
  endtask
  // Sets mode and options, then lets them settle.
  task automatic mode(input logic [2:0] m, input logic c, s, a);
    @(posedge clk);
    {hi, lo, address_mode_bit} <= m;
    cr_bit_interpret <= c;
    scrc <= s;
    sadd <= a;
    repeat (2) @(posedge clk);
  endtask
  // Works out the stored stream from byte k0 on; the last byte is the CRC.
  task automatic expect_rx(input int k0, input logic with_st);
    for (int k = k0; k < fn - 1; k++)
      eq.push_back({1'b0, fb[k]});
    if (scrc || !with_st)
      eq.push_back({1'b0, fb[fn-1]});
    if (with_st)
      eq.push_back({1'b0, st});
  endtask
  // Offers each byte and holds it until ready is seen at an edge.
  task automatic send(input logic frm);
    int w;
    @(posedge clk);
    fst <= st;
    for (int k = 0; k < fn; k++)
    begin
      rv <= 1'b1;
      rd <= fb[k];
      rs <= frm && k == 0;
      re <= frm && k == fn - 1;
      rc <= frm && k == fn - 1;
      w = 0;
      @(negedge clk);
      while (rrdy !== 1'b1 && w < 100)
      begin
        @(negedge clk);
        w++;
      end
      if (w == 100)
        hang();
      @(posedge clk);
    end
    rv <= 1'b0;
  endtask
  // Waits for the stream to arrive at the far side, then compares it.
  task automatic drain(input logic txs);
    logic [8:0] got[$];
    int w;
    for (w = 0; w < 400 && (txs ? p_u.tq.size() : p_u.rq.size()) < eq.size(); w++)
      @(posedge clk);
    if (w == 400)
      hang();
    repeat (8) @(posedge clk);
    @(negedge clk);
    if (txs)
      got = p_u.tq;
    else
      got = p_u.rq;
    chk9(9'(got.size()), 9'(eq.size()));
    foreach (eq[i])
      chk9(got[i], eq[i]);
    $display("case done at %0t, %0d entries", $time, eq.size());
    p_u.tq.delete();
    p_u.rq.delete();
    eq.delete();
  endtask
  // One received frame; k0 below zero means it must be dropped.
  task automatic rx_case(input logic [7:0] b0, b1, input int n, k0);
    fb[0] = b0;
    fb[1] = b1;
    for (int k = 2; k < 8; k++)
      fb[k] = next_rand();
    fn = n;
    st = next_rand();
    if (k0 >= 0)
      expect_rx(k0, !(hi && lo));
    send(1'b1);
    drain(1'b0);
  endtask
  // One transmitted frame of n FIFO bytes; n stays within the FIFO.
  task automatic tx_run(input logic info, input int n);
    logic [7:0] v;
    @(posedge clk);
    if (info)
    begin
      if (address_mode_bit)
        eq.push_back({1'b0, tah});
      eq.push_back({1'b0, tal});
      eq.push_back({1'b0, tct});
    end
    for (int k = 0; k < n; k++)
    begin
      v = next_rand();
      tsrc[k] <= v;
      eq.push_back({k == n - 1, v});
    end
    tidx <= 0;
    tlen <= n;
    ic <= info;
    tc <= !info;
    @(posedge clk);
    ic <= 1'b0;
    tc <= 1'b0;
    drain(1'b1);
  endtask
  // Main sequence: reset, receive modes, then transmit.
  initial
  begin
    repeat (4) @(posedge clk);
    x = next_rand();
    la <= x;
    lb <= x ^ 8'h01;
    tal <= x ^ 8'h22;
    tct <= next_rand();
    tah <= next_rand();
    rst_n <= 1'b1;
    @(negedge clk);
    chk1(fon, 1'b1);
    chk1(crcg, 1'b1);
    mode(3'b010, 1'b0, 1'b0, 1'b0);
    rx_case(lb, next_rand(), 4, 1);
    chk1(resp, 1'b1);
    mode(3'b010, 1'b0, 1'b1, 1'b1);
    rx_case(la, next_rand(), 4, 0);
    chk1(resp, 1'b0);
    rx_case(la ^ 8'h80, next_rand(), 4, -1);
    @(posedge clk) am <= 8'h80;
    rx_case(la ^ 8'h80, next_rand(), 4, 0);
    @(posedge clk) am <= 8'h00;
    mode(3'b001, 1'b1, 1'b0, 1'b0);
    rx_case(ha | 8'h02, la, 5, 2);
    chk1(ap, 1'b1);
    chk1(resp, 1'b1);
    rx_case(8'hFE, lb, 4, 2);
    chk1(ap, 1'b0);
    rx_case(hb, la ^ 8'h80, 4, -1);
    mode(3'b100, 1'b0, 1'b0, 1'b0);
    rx_case(next_rand(), next_rand(), 4, 0);
    chk9({1'b0, cap}, {1'b0, fb[0]});
    chk9({1'b0, cb}, {1'b0, fb[1]});
    chk9({1'b0, sb}, {1'b0, st});
    mode(3'b101, 1'b0, 1'b0, 1'b0);
    rx_case(8'hFC, next_rand(), 5, 1);
    chk9({1'b0, cap}, {1'b0, fb[1]});
    chk9({1'b0, cb}, {1'b0, fb[2]});
    rx_case(8'h00, next_rand(), 4, -1);
    mode(3'b111, 1'b0, 1'b0, 1'b0);
    chk1(fon, 1'b0);
    rx_case(next_rand(), next_rand(), 3, 0);
    expect_rx(0, 1'b0);
    send(1'b0);
    drain(1'b0);
    chk9({1'b0, cap}, {1'b0, fb[2]});
    mode(3'b110, 1'b0, 1'b0, 1'b0);
    fb[2] = ~fb[2];
    send(1'b0);
    drain(1'b0);
    chk9({1'b0, cap}, {1'b0, fb[2]});
    mode(3'b010, 1'b0, 1'b0, 1'b0);
    @(posedge clk) ic <= 1'b1;
    @(posedge clk) ic <= 1'b0;
    @(negedge clk);
    chk1(rej, 1'b1);
    tx_run(1'b0, 3);
    mode(3'b001, 1'b0, 1'b0, 1'b0);
    tx_run(1'b1, 4);
    @(posedge clk) xck <= 1'b1;
    tx_run(1'b0, 6);
    chk1(crcg, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
